// *** bench/jtag_host_model.sv ***
// behavioural debugger that drives the test pins of the port
`timescale 1ns/1ps

module jtag_host_model (
    input  wire logic ref_clk_i,
    input  wire logic test_data_i,
    output logic      test_clk_o,
    output logic      test_mode_sel_o,
    output logic      test_data_o,
    output logic      test_rst_o
);
    // ------------------------------------------------------------
    // pin drive, four reference clocks high and five low per test clock (360 ns)
    // ------------------------------------------------------------
    initial begin
        test_clk_o      = 1'b0;
        test_mode_sel_o = 1'b1;
        test_data_o     = 1'b1;
        test_rst_o      = 1'b0;
    end

    // one test clock: mode and data set up four reference clocks before the rise
    task automatic tick(input logic m, input logic d, output logic q);
        @(negedge ref_clk_i);
        test_mode_sel_o = m;
        test_data_o     = d;
        repeat (4) @(negedge ref_clk_i);
        test_clk_o = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        // output changed after the previous fall, so it has settled by now
        q          = test_data_i;
        test_clk_o = 1'b0;
    endtask

    // clock stands still between frames; idle lines sit at their pull-up level
    task automatic release_lines();
        @(negedge ref_clk_i);
        test_mode_sel_o = 1'b1;
        test_data_o     = 1'b1;
    endtask

    task automatic set_test_rst(input logic v);
        @(negedge ref_clk_i);
        test_rst_o = v;
        repeat (8) @(negedge ref_clk_i);
    endtask

    task automatic reset_tap();
        logic q;
        repeat (5) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        release_lines();
    endtask

    // from run-test/idle through one shift, back to run-test/idle, LSB first
    task automatic scan(input logic ir, input int w, input logic [31:0] d, output logic [31:0] got);
        logic q;
        got = 32'h0000_0000;
        tick(1'b1, 1'b1, q);
        if (ir) begin
            tick(1'b1, 1'b1, q);
        end
        tick(1'b0, 1'b1, q);
        tick(1'b0, 1'b1, q);
        for (int i = 0; i < w; i++) begin
            tick(i == w - 1, d[i], q);
            got[i] = q;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        release_lines();
    endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench of the test access port
`timescale 1ns/1ps

module testbench;
    import tap_port_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h5A5A_0F01;  // arbitrary identity value

    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ext_a     = 1'b1;
    logic ext_b     = 1'b1;
    logic clk_en    = 1'b1;
    logic raise_a   = 1'b0;
    logic raise_b   = 1'b0;
    logic [7:0] bsr_in = 8'h00;
    logic tck, tms, tdi, trst, tdo, tdo_oe_n, tdo_w;
    logic a_o, a_oe_n, b_o, b_oe_n, a_w, b_w, irq_a, irq_b, scan_ctl, bs_mode;
    logic [7:0] bsr_out;
    logic [31:0] q;
    int error_cnt = 0;
    int compares  = 0;
    int cyc       = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    // ------------------------------------------------------------
    // wire levels: a released event pin takes the external level, a released data output reads inverted
    // ------------------------------------------------------------
    assign a_w   = a_oe_n ? ext_a : a_o;
    assign b_w   = b_oe_n ? ext_b : b_o;
    assign tdo_w = tdo_oe_n ? ~tdo : tdo;

    jtag_emulation_port #(.IDCODE_VALUE(ID_VAL), .BSR_WIDTH(8)) i_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
        .test_clk_i(tck), .test_mode_sel_i(tms), .test_data_i(tdi), .test_rst_i(trst),
        .test_data_o(tdo), .test_data_oe_n_o(tdo_oe_n),
        .debug_event_pin_a_i(a_w), .debug_event_pin_a_o(a_o), .debug_event_pin_a_oe_n_o(a_oe_n),
        .debug_event_pin_b_i(b_w), .debug_event_pin_b_o(b_o), .debug_event_pin_b_oe_n_o(b_oe_n),
        .event_a_irq_o(irq_a), .event_b_irq_o(irq_b),
        .event_a_raise_i(raise_a), .event_b_raise_i(raise_b),
        .bsr_pins_i(bsr_in), .bsr_pins_o(bsr_out),
        .scan_control_o(scan_ctl), .boundary_scan_mode_o(bs_mode)
    );

    jtag_host_model i_host (
        .ref_clk_i(ref_clk_i), .test_data_i(tdo_w), .test_clk_o(tck),
        .test_mode_sel_o(tms), .test_data_o(tdi), .test_rst_o(trst)
    );

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_mode_latch();
        check("scan control low", 32'(0), 32'(scan_ctl));
        @(negedge ref_clk_i);
        ext_b = 1'b0;
        i_host.set_test_rst(1'b1);
        check("scan mode latched", 32'(1), 32'(bs_mode));
        check("scan control high", 32'(1), 32'(scan_ctl));
        i_host.set_test_rst(1'b0);
        ext_a = 1'b0;
        i_host.set_test_rst(1'b1);
        check("scan mode cleared", 32'(0), 32'(bs_mode));
        ext_a = 1'b1;
        ext_b = 1'b1;
    endtask

    task automatic s_idcode_bypass();
        i_host.reset_tap();
        i_host.scan(1'b0, 32, 32'h0000_0000, q);
        check("identity", ID_VAL, q);
        i_host.scan(1'b1, 4, 32'h0000_000F, q);
        check("ir capture", 32'h0000_0001, q);
        i_host.scan(1'b0, 3, 32'h0000_0003, q);
        check("bypass", 32'h0000_0006, q);
    endtask

    task automatic s_extest();
        bsr_in = 8'h3C;
        i_host.scan(1'b1, 4, 32'h0000_0000, q);
        i_host.scan(1'b0, 8, 32'h0000_00A5, q);
        check("bsr capture", 32'h0000_003C, q);
        check("bsr update", 32'h0000_00A5, 32'(bsr_out));
    endtask

    task automatic s_events();
        i_host.scan(1'b1, 4, 32'h0000_0008, q);
        i_host.scan(1'b0, 4, 32'h0000_0005, q);
        check("event ctrl capture", 32'h0000_0000, q);
        repeat (4) @(negedge ref_clk_i);
        check("pin a enable", 32'(0), 32'(a_oe_n));
        check("pin a value", 32'(1), 32'(a_o));
        check("pin b enable", 32'(1), 32'(b_oe_n));
        check("pin a no irq while driven", 32'(0), 32'(irq_a));
        raise_b = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("pin b raised value", 32'(1), 32'(b_o));
        raise_b = 1'b0;
        ext_b = 1'b1;
        repeat (8) @(negedge ref_clk_i);
        check("pin b irq high", 32'(1), 32'(irq_b));
        ext_b = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        check("pin b irq low", 32'(0), 32'(irq_b));
        // a low enable freezes the synchronisers, so the pin change must wait
        clk_en = 1'b0;
        ext_b  = 1'b1;
        repeat (8) @(negedge ref_clk_i);
        check("pin b irq frozen", 32'(0), 32'(irq_b));
        clk_en = 1'b1;
        repeat (8) @(negedge ref_clk_i);
        check("pin b irq after enable", 32'(1), 32'(irq_b));
        i_host.set_test_rst(1'b0);
        check("pin a released", 32'(1), 32'(a_oe_n));
        raise_a = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("pin a raised value", 32'(1), 32'(a_o));
        raise_a = 1'b0;
        i_host.set_test_rst(1'b1);
        // held reset left the controller in reset: one low mode bit reaches idle
        i_host.tick(1'b0, 1'b1, q[0]);
        // held reset must have returned the instruction to identity
        i_host.scan(1'b0, 32, 32'h0000_0000, q);
        check("identity after reset", ID_VAL, q);
    endtask

    initial begin
        repeat (8) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        s_mode_latch();
        s_idcode_bypass();
        s_extest();
        s_events();
        summarize();
    end
endmodule

// *** logic/jtag_emulation_port.sv ***
// test access port with debug event pins and boundary-scan mode latch
`timescale 1ns/1ps
`include "tap_port_map.svh"

module jtag_emulation_port
    import tap_port_pkg::*;
#(
    parameter int unsigned IDCODE_VALUE = 32'h0000_0001,  // arbitrary identity value
    parameter int unsigned BSR_WIDTH    = 8
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 test_clk_i,
    input  wire logic                 test_mode_sel_i,
    input  wire logic                 test_data_i,
    input  wire logic                 test_rst_i,
    output logic                      test_data_o,
    output logic                      test_data_oe_n_o,
    input  wire logic                 debug_event_pin_a_i,
    output logic                      debug_event_pin_a_o,
    output logic                      debug_event_pin_a_oe_n_o,
    input  wire logic                 debug_event_pin_b_i,
    output logic                      debug_event_pin_b_o,
    output logic                      debug_event_pin_b_oe_n_o,
    output logic                      event_a_irq_o,
    output logic                      event_b_irq_o,
    input  wire logic                 event_a_raise_i,
    input  wire logic                 event_b_raise_i,
    input  wire logic [BSR_WIDTH-1:0] bsr_pins_i,
    output logic      [BSR_WIDTH-1:0] bsr_pins_o,
    output logic                      scan_control_o,
    output logic                      boundary_scan_mode_o
);

    initial begin
        if (BSR_WIDTH < 1 || BSR_WIDTH > 64) begin
            $error("BSR_WIDTH out of range");
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // three stages; a change is accepted once stages two and three agree
    localparam int unsigned NSYNC = 6;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] flt_q;
    assign raw = {debug_event_pin_b_i, debug_event_pin_a_i, test_rst_i,
                  test_data_i, test_mode_sel_i, test_clk_i};

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            flt_q <= '0;
        end else if (clk_en_i) begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    flt_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic tck_q;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst;
    logic pin_a;
    logic pin_b;
    logic trst_prev_q;
    assign {pin_b, pin_a, trst, tdi, tms} = flt_q[5:1];
    assign tck_rise = clk_en_i && flt_q[0] && !tck_q;
    assign tck_fall = clk_en_i && !flt_q[0] && tck_q;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tck_q       <= 1'b0;
            trst_prev_q <= 1'b0;
        end else if (clk_en_i) begin
            tck_q       <= flt_q[0];
            trst_prev_q <= trst;
        end
    end

    // ----------------------------------------------------------------
    // controller
    // ----------------------------------------------------------------
    tap_state_t state_q;
    tap_state_t state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TEST_LOGIC_RESET: state_d = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE:    state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR:        state_d = tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR:       state_d = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:         state_d = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:         state_d = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:         state_d = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:         state_d = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:        state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR:        state_d = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR:       state_d = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:         state_d = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:         state_d = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:         state_d = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:         state_d = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:        state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
        endcase
    end

    // test reset low keeps the port in reset so the device runs functionally
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= TEST_LOGIC_RESET;
        end else if (clk_en_i) begin
            if (!trst) begin
                state_q <= TEST_LOGIC_RESET;
            end else if (tck_rise) begin
                state_q <= state_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // instruction and data registers
    // ----------------------------------------------------------------
    logic [`TAP_IR_WIDTH-1:0]       ir_sh_q;
    logic [`TAP_IR_WIDTH-1:0]       ir_q;
    logic [31:0]                    id_sh_q;
    logic                           byp_q;
    logic [BSR_WIDTH-1:0]           bsr_sh_q;
    logic [`TAP_EVT_CTRL_WIDTH-1:0] evt_sh_q;
    logic [`TAP_EVT_CTRL_WIDTH-1:0] evt_q;

    function automatic logic dr_serial_out(input logic [`TAP_IR_WIDTH-1:0] op,
                                           input logic id0, input logic b,
                                           input logic bs0, input logic ev0);
        dr_serial_out = b;
        if (op == `TAP_OP_IDCODE) begin
            dr_serial_out = id0;
        end else if (op == `TAP_OP_EXTEST) begin
            dr_serial_out = bs0;
        end else if (op == `TAP_OP_EVENT_CTRL) begin
            dr_serial_out = ev0;
        end
    endfunction

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ir_sh_q  <= `TAP_IR_RESET;
            ir_q     <= `TAP_IR_RESET;
            id_sh_q  <= '0;
            byp_q    <= 1'b0;
            bsr_sh_q <= '0;
            evt_sh_q <= `TAP_EVT_CTRL_RESET;
            evt_q    <= `TAP_EVT_CTRL_RESET;
            bsr_pins_o <= '0;
        end else if (clk_en_i) begin
            if (state_q == TEST_LOGIC_RESET) begin
                ir_q  <= `TAP_IR_RESET;
                evt_q <= `TAP_EVT_CTRL_RESET;
            end else if (tck_rise) begin
                unique case (state_q)
                    CAPTURE_IR: ir_sh_q <= `TAP_IR_CAPTURE;
                    SHIFT_IR:   ir_sh_q <= {tdi, ir_sh_q[`TAP_IR_WIDTH-1:1]};
                    UPDATE_IR:  ir_q <= ir_sh_q;
                    CAPTURE_DR: begin
                        id_sh_q  <= IDCODE_VALUE;
                        byp_q    <= 1'b0;
                        bsr_sh_q <= bsr_pins_i;
                        evt_sh_q <= evt_q;
                    end
                    SHIFT_DR: begin
                        if (ir_q == `TAP_OP_IDCODE) begin
                            id_sh_q <= {tdi, id_sh_q[31:1]};
                        end else if (ir_q == `TAP_OP_EXTEST) begin
                            bsr_sh_q <= {tdi, bsr_sh_q[BSR_WIDTH-1:1]};
                        end else if (ir_q == `TAP_OP_EVENT_CTRL) begin
                            evt_sh_q <= {tdi, evt_sh_q[`TAP_EVT_CTRL_WIDTH-1:1]};
                        end else begin
                            byp_q <= tdi;
                        end
                    end
                    UPDATE_DR: begin
                        if (ir_q == `TAP_OP_EVENT_CTRL) begin
                            evt_q <= evt_sh_q;
                        end else if (ir_q == `TAP_OP_EXTEST) begin
                            bsr_pins_o <= bsr_sh_q;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // serial output, changed on the falling edge
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            test_data_o      <= 1'b0;
            test_data_oe_n_o <= 1'b1;
        end else if (clk_en_i && tck_fall) begin
            test_data_oe_n_o <= !(state_q == SHIFT_IR || state_q == SHIFT_DR);
            if (state_q == SHIFT_IR) begin
                test_data_o <= ir_sh_q[0];
            end else if (state_q == SHIFT_DR) begin
                test_data_o <= dr_serial_out(ir_q, id_sh_q[0], byp_q, bsr_sh_q[0], evt_sh_q[0]);
            end
        end
    end

    // ----------------------------------------------------------------
    // debug event pins and boundary-scan latch
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            debug_event_pin_a_o      <= 1'b0;
            debug_event_pin_b_o      <= 1'b0;
            debug_event_pin_a_oe_n_o <= 1'b1;
            debug_event_pin_b_oe_n_o <= 1'b1;
            event_a_irq_o            <= 1'b0;
            event_b_irq_o            <= 1'b0;
        end else if (clk_en_i) begin
            // direction bit set: drive out; clear: the debugger drives us
            debug_event_pin_a_oe_n_o <= !(trst && evt_q[`TAP_EVT_DIR_A_BIT]);
            debug_event_pin_b_oe_n_o <= !(trst && evt_q[`TAP_EVT_DIR_B_BIT]);
            debug_event_pin_a_o      <= evt_q[`TAP_EVT_VAL_A_BIT] | event_a_raise_i;
            debug_event_pin_b_o      <= evt_q[`TAP_EVT_VAL_B_BIT] | event_b_raise_i;
            event_a_irq_o <= trst && !evt_q[`TAP_EVT_DIR_A_BIT] && pin_a;
            event_b_irq_o <= trst && !evt_q[`TAP_EVT_DIR_B_BIT] && pin_b;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            boundary_scan_mode_o <= 1'b0;
            scan_control_o       <= 1'b0;
        end else if (clk_en_i) begin
            scan_control_o <= trst;
            if (trst && !trst_prev_q) begin
                boundary_scan_mode_o <= pin_a && !pin_b;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_reset_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && !trst) |=> state_q == TEST_LOGIC_RESET)
        else $error("controller left reset while test reset low");

    chk_state_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && trst && tck_rise) |=> state_q == $past(state_d))
        else $error("controller did not step on test clock rise");

    chk_state_still: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && trst && !tck_rise) |=> $stable(state_q))
        else $error("controller moved without a test clock rise");

    chk_ir_shift: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (tck_rise && trst && state_q == SHIFT_IR) |=> ir_sh_q[`TAP_IR_WIDTH-1] == $past(tdi))
        else $error("instruction shift lost data input");

    chk_tdo_fall: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!tck_fall) |=> $stable(test_data_o))
        else $error("data output changed off a falling edge");

    chk_tdo_ir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (tck_fall && state_q == SHIFT_IR) |=> test_data_o == $past(ir_sh_q[0]) && !test_data_oe_n_o)
        else $error("data output not instruction bit");

    chk_evt_dir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && !trst) |=> debug_event_pin_a_oe_n_o && debug_event_pin_b_oe_n_o)
        else $error("event pin driven while test reset low");

    chk_bscan_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && trst && !trst_prev_q && pin_a && !pin_b) |=> boundary_scan_mode_o)
        else $error("boundary-scan mode not latched");

    chk_bscan_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && !(trst && !trst_prev_q)) |=> $stable(boundary_scan_mode_o))
        else $error("boundary-scan mode changed without test reset rise");

endmodule

// *** logic/tap_port_map.svh ***
// offsets, encodings and timing constants of the test access port
`ifndef TAP_PORT_MAP_SVH
`define TAP_PORT_MAP_SVH

`define TAP_IR_WIDTH        4
`define TAP_IR_RESET        4'h1
`define TAP_IR_CAPTURE      4'h1
`define TAP_OP_EXTEST       4'h0
`define TAP_OP_IDCODE       4'h1
`define TAP_OP_EVENT_CTRL   4'h8
`define TAP_OP_BYPASS       4'hF
`define TAP_EVT_CTRL_WIDTH  4
`define TAP_EVT_CTRL_RESET  4'h0
`define TAP_EVT_DIR_A_BIT   0
`define TAP_EVT_DIR_B_BIT   1
`define TAP_EVT_VAL_A_BIT   2
`define TAP_EVT_VAL_B_BIT   3
`define TAP_LINK_CLK_NS     320
`define TAP_REF_CLK_NS      40

`endif

// *** logic/tap_port_pkg.sv ***
// types of the test access port
package tap_port_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

endpackage
